// ===== clockgen_pkg.sv
// Constants and carriers shared by the serial control register bank and its helpers.
// Assumes a SystemVerilog compiler; nothing here is synthesised on its own.
package clockgen_pkg;

    // ==========================================================
    // Serial addressing and command code layout
    localparam logic [7:0] DEVICE_ADDR_WRITE = 8'hD2;
    localparam logic [7:0] DEVICE_ADDR_READ = 8'hD3;
    localparam int CMD_BYTE_MODE_BIT = 7;
    localparam int CMD_SELECT_MSB = 6;
    localparam int CMD_SELECT_LSB = 5;
    localparam logic [1:0] CMD_SELECT_VALUE = 2'h0;
    localparam int CMD_OFFSET_MSB = 4;
    localparam int CMD_OFFSET_USED_MSB = 2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LINK_RESET_STRETCH = 4'hF;

    // ==========================================================
    // Register offsets
    localparam int REG_COUNT = 8;
    localparam int STORED_COUNT = 7;
    localparam logic [2:0] OFS_OUTPUT_ENABLE_CONTROL = 3'h0;
    localparam logic [2:0] OFS_RESERVED_CONTROL_ONE = 3'h1;
    localparam logic [2:0] OFS_SPREAD_SPECTRUM_CONTROL = 3'h2;
    localparam logic [2:0] OFS_RESERVED_CONTROL_THREE = 3'h3;
    localparam logic [2:0] OFS_RESERVED_CONTROL_FOUR = 3'h4;
    localparam logic [2:0] OFS_RESERVED_CONTROL_FIVE = 3'h5;
    localparam logic [2:0] OFS_TEST_MODE_CONTROL = 3'h6;
    localparam logic [2:0] OFS_IDENTIFICATION = 3'h7;

    // ==========================================================
    // Power-up values and writable bits, indexed by offset
    localparam logic [7:0] REG_RESET [0:STORED_COUNT-1] = '{
        8'h7C, 8'h00, 8'hEB, 8'hAF, 8'h01, 8'h00, 8'h13};
    localparam logic [7:0] REG_WRITE_MASK [0:STORED_COUNT-1] = '{
        8'h18, 8'h00, 8'h84, 8'h00, 8'h00, 8'h00, 8'hC0};

    // ==========================================================
    // Field positions
    localparam int PAIR2_ENABLE_BIT = 4;
    localparam int PAIR1_ENABLE_BIT = 3;
    localparam int SPREAD_DEPTH_BIT = 7;
    localparam int SPREAD_ENABLE_BIT = 2;
    localparam int TEST_SELECT_BIT = 7;
    localparam int TEST_MODE_BIT = 6;
    localparam int REVISION_MSB = 7;
    localparam int VENDOR_MSB = 3;

    // Control settings handed from the serial domain to the output domain.
    typedef struct packed {
        logic pair2_enable;
        logic pair1_enable;
        logic spread_depth_select;
        logic spread_enable;
        logic test_mode;
        logic test_select;
    } clock_config_s;

endpackage

// ===== sync_three.sv
// Three-stage input synchroniser; the output moves once stages two and three agree.
// Assumes the input is asynchronous to clock; no reset, the level settles in four edges.
`timescale 1ns/1ns
module sync_three #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] mid_reg;
    logic [WIDTH-1:0] last_reg;
    logic [WIDTH-1:0] level_reg;

    if (WIDTH < 1) begin : g_bad_width
        $error("sync_three needs a width of at least one");
    end

    always_ff @(posedge clock) begin
        meta_reg <= async_in;
        mid_reg <= meta_reg;
        last_reg <= mid_reg;
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < WIDTH; i++) begin
            if (mid_reg[i] == last_reg[i]) begin
                level_reg[i] <= last_reg[i];
            end
        end
    end

    assign level = level_reg;
endmodule

// ===== pair_gate.sv
// Output stage of one differential pair with a glitch-free enable.
// Assumes level is a clock level produced in the clock domain of this module.
`timescale 1ns/1ns
module pair_gate (
    input wire logic clock,
    input wire logic reset,
    input wire logic level,
    input wire logic want_enable,
    output logic true_out,
    output logic comp_out,
    output logic oe_n
);
    logic enable_reg;
    logic true_reg;
    logic comp_reg;
    logic oe_n_reg;

    // The enable only moves while the clock is low, so no high pulse is cut short.
    always_ff @(posedge clock) begin
        if (reset) begin
            enable_reg <= 1'b0;
        end else if (!level) begin
            enable_reg <= want_enable;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            true_reg <= 1'b0;
            comp_reg <= 1'b1;
            oe_n_reg <= 1'b1;
        end else begin
            true_reg <= level;
            comp_reg <= ~level;
            oe_n_reg <= ~enable_reg;
        end
    end

    assign true_out = true_reg;
    assign comp_out = comp_reg;
    assign oe_n = oe_n_reg;

    AST_ENABLE_ON_LOW: assert property (@(posedge clock) disable iff (reset)
        $changed(enable_reg) |-> !$past(level))
        else $error("Pair enable changed while the clock was high.");
endmodule

// ===== clockgen_serial_control_regs.sv
// Serial-programmed control register bank of a spread-spectrum clock generator.
// Assumes an open-drain data line with pull-up outside, and clock levels made on clock.
//
// Contract
// - Byte write: address, command, data, stop.
// - Byte read: repeated start, address read, one byte.
// - Byte 0 bit 4 enables second pair.
// - Byte 0 bit 3 enables first pair.
// - Byte 2 bit 7 selects spread depth.
// - Byte 2 bit 2 turns spreading on.
// - Byte 6 bit 6 enters test clock mode.
// - Byte 6 bit 7: hi-Z or reference clock.
// - Byte 7 returns revision and vendor code.
// - Bytes 0 to 6 load power-up defaults.
// - Command: byte mode, select 00, offset.
// - Respond only to our address byte.
`timescale 1ns/1ns
module clockgen_serial_control_regs #(
    parameter logic [3:0] REVISION_CODE = 4'h3, // Arbitrary value.
    parameter logic [3:0] VENDOR_ID = 4'h5, // Arbitrary value.
    parameter int PAIR_COUNT = 2
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic link_clock,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    input wire logic source_clock_level,
    input wire logic ref_clock_level,
    output logic [PAIR_COUNT-1:0] pair_true_out,
    output logic [PAIR_COUNT-1:0] pair_comp_out,
    output logic [PAIR_COUNT-1:0] pair_oe_n,
    output logic spread_enable,
    output logic spread_depth_select,
    output logic test_mode_active
);
    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_IGNORE
    } link_state_e;

    if (PAIR_COUNT < 1 || PAIR_COUNT > 2) begin : g_bad_pairs
        $error("PAIR_COUNT must be one or two");
    end

    function automatic clockgen_pkg::clock_config_s config_of(
        input logic [7:0] enables, input logic [7:0] spread, input logic [7:0] test);
        clockgen_pkg::clock_config_s c;
        c.pair2_enable = enables[clockgen_pkg::PAIR2_ENABLE_BIT];
        c.pair1_enable = enables[clockgen_pkg::PAIR1_ENABLE_BIT];
        c.spread_depth_select = spread[clockgen_pkg::SPREAD_DEPTH_BIT];
        c.spread_enable = spread[clockgen_pkg::SPREAD_ENABLE_BIT];
        c.test_mode = test[clockgen_pkg::TEST_MODE_BIT];
        c.test_select = test[clockgen_pkg::TEST_SELECT_BIT];
        return c;
    endfunction

    localparam clockgen_pkg::clock_config_s CFG_RESET = config_of(
        clockgen_pkg::REG_RESET[clockgen_pkg::OFS_OUTPUT_ENABLE_CONTROL],
        clockgen_pkg::REG_RESET[clockgen_pkg::OFS_SPREAD_SPECTRUM_CONTROL],
        clockgen_pkg::REG_RESET[clockgen_pkg::OFS_TEST_MODE_CONTROL]);

    // ==========================================================
    // Reset stretch so that a short reset still spans many link clock edges
    logic [3:0] reset_stretch_reg;
    logic link_reset_req_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            reset_stretch_reg <= clockgen_pkg::LINK_RESET_STRETCH;
        end else if (reset_stretch_reg != 4'h0) begin
            reset_stretch_reg <= reset_stretch_reg - 4'h1;
        end
    end

    // A registered request keeps the crossing free of combinational glitches.
    always_ff @(posedge clock) begin
        link_reset_req_reg <= reset || reset_stretch_reg != 4'h0;
    end

    // ==========================================================
    // Link domain: synchronised pins and reset
    logic link_reset;
    logic [1:0] pins_level;
    logic scl_s;
    logic sda_s;
    logic scl_prev_reg;
    logic sda_prev_reg;

    sync_three #(.WIDTH(1)) u_reset_sync (
        .clock(link_clock),
        .async_in(link_reset_req_reg),
        .level(link_reset)
    );

    sync_three #(.WIDTH(2)) u_pin_sync (
        .clock(link_clock),
        .async_in({serial_clock_in, serial_data_in}),
        .level(pins_level)
    );

    assign scl_s = pins_level[1];
    assign sda_s = pins_level[0];

    always_ff @(posedge link_clock) begin
        if (link_reset) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise = scl_s && !scl_prev_reg;
    assign scl_fall = !scl_s && scl_prev_reg;
    assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
    assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

    // ==========================================================
    // Link domain: byte protocol engine
    link_state_e state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [2:0] offset_reg;
    logic cmd_valid_reg;
    logic read_reg;
    logic drive_low_reg;
    logic [7:0] regs_reg [0:clockgen_pkg::STORED_COUNT-1];
    logic [7:0] read_value;
    logic cmd_ok;
    logic commit;

    assign cmd_ok = shift_reg[clockgen_pkg::CMD_BYTE_MODE_BIT]
        && shift_reg[clockgen_pkg::CMD_SELECT_MSB:clockgen_pkg::CMD_SELECT_LSB] == clockgen_pkg::CMD_SELECT_VALUE
        && shift_reg[clockgen_pkg::CMD_OFFSET_MSB:clockgen_pkg::CMD_OFFSET_USED_MSB+1] == 2'h0;
    assign read_value = (offset_reg == clockgen_pkg::OFS_IDENTIFICATION) ?
        {REVISION_CODE, VENDOR_ID} : regs_reg[offset_reg];
    assign commit = state_reg == ST_WDATA_ACK && scl_fall;

    always_ff @(posedge link_clock) begin
        if (link_reset || stop_det) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            offset_reg <= 3'h0;
            cmd_valid_reg <= 1'b0;
            read_reg <= 1'b0;
            drive_low_reg <= 1'b0;
        end else if (start_det) begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            drive_low_reg <= 1'b0;
        end else if (scl_rise) begin
            if (state_reg inside {ST_ADDR, ST_CMD, ST_WDATA}) begin
                shift_reg <= {shift_reg[6:0], sda_s};
            end
            if (state_reg inside {ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA}) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end else if (scl_fall) begin
            unique case (state_reg)
                ST_IDLE, ST_IGNORE, ST_RDATA_ACK: begin
                    state_reg <= (state_reg == ST_IDLE) ? ST_IDLE : ST_IGNORE;
                    drive_low_reg <= 1'b0;
                end
                ST_ADDR: begin
                    if (bit_cnt_reg == clockgen_pkg::BITS_PER_BYTE) begin
                        if (shift_reg == clockgen_pkg::DEVICE_ADDR_WRITE) begin
                            state_reg <= ST_ADDR_ACK;
                            read_reg <= 1'b0;
                            drive_low_reg <= 1'b1;
                        end else if (shift_reg == clockgen_pkg::DEVICE_ADDR_READ && cmd_valid_reg) begin
                            state_reg <= ST_ADDR_ACK;
                            read_reg <= 1'b1;
                            drive_low_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    bit_cnt_reg <= 4'h0;
                    if (read_reg) begin
                        state_reg <= ST_RDATA;
                        shift_reg <= read_value;
                        drive_low_reg <= !read_value[7];
                    end else begin
                        state_reg <= ST_CMD;
                        drive_low_reg <= 1'b0;
                    end
                end
                ST_CMD: begin
                    if (bit_cnt_reg == clockgen_pkg::BITS_PER_BYTE) begin
                        if (cmd_ok) begin
                            state_reg <= ST_CMD_ACK;
                            offset_reg <= shift_reg[clockgen_pkg::CMD_OFFSET_USED_MSB:0];
                            cmd_valid_reg <= 1'b1;
                            drive_low_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_CMD_ACK: begin
                    state_reg <= ST_WDATA;
                    bit_cnt_reg <= 4'h0;
                    drive_low_reg <= 1'b0;
                end
                ST_WDATA: begin
                    if (bit_cnt_reg == clockgen_pkg::BITS_PER_BYTE) begin
                        state_reg <= ST_WDATA_ACK;
                        drive_low_reg <= 1'b1;
                    end
                end
                ST_WDATA_ACK: begin
                    state_reg <= ST_IGNORE;
                    drive_low_reg <= 1'b0;
                end
                ST_RDATA: begin
                    if (bit_cnt_reg == clockgen_pkg::BITS_PER_BYTE) begin
                        state_reg <= ST_RDATA_ACK;
                        drive_low_reg <= 1'b0;
                    end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        drive_low_reg <= !shift_reg[6];
                    end
                end
            endcase
        end
    end

    assign serial_data_out = 1'b0;
    assign serial_data_oe_n = !drive_low_reg;

    // ==========================================================
    // Link domain: register storage
    always_ff @(posedge link_clock) begin
        if (link_reset) begin
            for (int i = 0; i < clockgen_pkg::STORED_COUNT; i++) begin
                regs_reg[i] <= clockgen_pkg::REG_RESET[i];
            end
        end else if (commit && offset_reg != clockgen_pkg::OFS_IDENTIFICATION) begin
            regs_reg[offset_reg] <= (clockgen_pkg::REG_RESET[offset_reg] & ~clockgen_pkg::REG_WRITE_MASK[offset_reg])
                | (shift_reg & clockgen_pkg::REG_WRITE_MASK[offset_reg]);
        end
    end

    // The settings word is held still for many link cycles while its toggle crosses.
    clockgen_pkg::clock_config_s cfg_hold_reg;
    logic cfg_toggle_reg;
    always_ff @(posedge link_clock) begin
        if (link_reset) begin
            cfg_hold_reg <= CFG_RESET;
            cfg_toggle_reg <= 1'b0;
        end else if (commit) begin
            cfg_hold_reg <= config_of(
                (offset_reg == clockgen_pkg::OFS_OUTPUT_ENABLE_CONTROL) ? shift_reg :
                    regs_reg[clockgen_pkg::OFS_OUTPUT_ENABLE_CONTROL],
                (offset_reg == clockgen_pkg::OFS_SPREAD_SPECTRUM_CONTROL) ? shift_reg :
                    regs_reg[clockgen_pkg::OFS_SPREAD_SPECTRUM_CONTROL],
                (offset_reg == clockgen_pkg::OFS_TEST_MODE_CONTROL) ? shift_reg :
                    regs_reg[clockgen_pkg::OFS_TEST_MODE_CONTROL]);
            cfg_toggle_reg <= !cfg_toggle_reg;
        end
    end

    // ==========================================================
    // Output domain: settings capture and output gating
    logic toggle_level;
    logic toggle_seen_reg;
    clockgen_pkg::clock_config_s cfg_main_reg;

    sync_three #(.WIDTH(1)) u_toggle_sync (
        .clock(clock),
        .async_in(cfg_toggle_reg),
        .level(toggle_level)
    );

    always_ff @(posedge clock) begin
        if (reset || link_reset_req_reg) begin
            toggle_seen_reg <= 1'b0;
            cfg_main_reg <= CFG_RESET;
        end else if (toggle_level != toggle_seen_reg) begin
            toggle_seen_reg <= toggle_level;
            cfg_main_reg <= cfg_hold_reg;
        end
    end

    assign spread_enable = cfg_main_reg.spread_enable;
    assign spread_depth_select = cfg_main_reg.spread_depth_select;
    assign test_mode_active = cfg_main_reg.test_mode;

    // Source and forced-off mode switch only while both clocks are low.
    logic use_ref_reg;
    logic force_off_reg;
    logic selected_level;
    logic [1:0] pair_want;
    always_ff @(posedge clock) begin
        if (reset) begin
            use_ref_reg <= 1'b0;
            force_off_reg <= 1'b0;
        end else if (!source_clock_level && !ref_clock_level) begin
            use_ref_reg <= cfg_main_reg.test_mode && cfg_main_reg.test_select;
            force_off_reg <= cfg_main_reg.test_mode && !cfg_main_reg.test_select;
        end
    end

    assign selected_level = use_ref_reg ? ref_clock_level : source_clock_level;
    assign pair_want[0] = !force_off_reg && (use_ref_reg || cfg_main_reg.pair1_enable);
    assign pair_want[1] = !force_off_reg && (use_ref_reg || cfg_main_reg.pair2_enable);

    for (genvar p = 0; p < PAIR_COUNT; p++) begin : g_pair
        pair_gate u_gate (
            .clock(clock),
            .reset(reset),
            .level(selected_level),
            .want_enable(pair_want[p]),
            .true_out(pair_true_out[p]),
            .comp_out(pair_comp_out[p]),
            .oe_n(pair_oe_n[p])
        );
    end

    // ==========================================================
    // Checks
    AST_FOREIGN_ADDR_NACK: assert property (@(posedge link_clock) disable iff (link_reset)
        state_reg == ST_ADDR && scl_fall && !start_det && bit_cnt_reg == clockgen_pkg::BITS_PER_BYTE
        && shift_reg != clockgen_pkg::DEVICE_ADDR_WRITE && shift_reg != clockgen_pkg::DEVICE_ADDR_READ
        |=> serial_data_oe_n && state_reg != ST_ADDR_ACK)
        else $error("Device answered a foreign address.");

    AST_BLOCK_CMD_REJECT: assert property (@(posedge link_clock) disable iff (link_reset)
        state_reg == ST_CMD && scl_fall && !start_det && !stop_det
        && bit_cnt_reg == clockgen_pkg::BITS_PER_BYTE && !shift_reg[clockgen_pkg::CMD_BYTE_MODE_BIT]
        |=> state_reg == ST_IGNORE && serial_data_oe_n)
        else $error("Command without byte mode was acknowledged.");

    AST_ACK_DRIVES_LOW: assert property (@(posedge link_clock) disable iff (link_reset)
        state_reg inside {ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK} |-> !serial_data_oe_n)
        else $error("Acknowledge bit not driven low.");

    AST_COMMIT_TOGGLES: assert property (@(posedge link_clock) disable iff (link_reset)
        commit && !start_det && !stop_det |=> cfg_toggle_reg != $past(cfg_toggle_reg) ##1 state_reg != ST_WDATA_ACK)
        else $error("Data acknowledge did not publish the new settings.");

    AST_READ_ID_VALUE: assert property (@(posedge link_clock) disable iff (link_reset)
        state_reg == ST_ADDR_ACK && scl_fall && !start_det && !stop_det && read_reg
        && offset_reg == clockgen_pkg::OFS_IDENTIFICATION
        |=> shift_reg == {REVISION_CODE, VENDOR_ID} && state_reg == ST_RDATA)
        else $error("Identification byte not loaded for readout.");

    AST_RESERVED_KEPT: assert property (@(posedge link_clock) disable iff (link_reset)
        commit |=> regs_reg[clockgen_pkg::OFS_RESERVED_CONTROL_ONE] == clockgen_pkg::REG_RESET[1]
        && (regs_reg[0] & ~clockgen_pkg::REG_WRITE_MASK[0]) == (clockgen_pkg::REG_RESET[0] & ~clockgen_pkg::REG_WRITE_MASK[0]))
        else $error("A reserved bit changed on a write.");

    AST_DEFAULTS_AFTER_RESET: assert property (@(posedge link_clock)
        $fell(link_reset) |-> regs_reg[2] == clockgen_pkg::REG_RESET[2] && regs_reg[6] == clockgen_pkg::REG_RESET[6]
        && cfg_hold_reg == CFG_RESET)
        else $error("Registers left reset without their power-up values.");

    AST_SPREAD_FOLLOWS: assert property (@(posedge clock) disable iff (reset)
        toggle_level != toggle_seen_reg |=> spread_enable == cfg_hold_reg.spread_enable
        && spread_depth_select == cfg_hold_reg.spread_depth_select)
        else $error("Spread settings did not follow the written value.");

    AST_TEST_HIZ: assert property (@(posedge clock) disable iff (reset)
        force_off_reg && !source_clock_level |-> ##2 pair_oe_n[0])
        else $error("Test high impedance mode left a pair driven.");

    AST_PAIR1_OFF: assert property (@(posedge clock) disable iff (reset)
        !pair_want[0] && !selected_level ##1 !pair_want[0] |-> ##1 pair_oe_n[0])
        else $error("First pair stayed driven after being disabled.");

    COV_WRITE: cover property (@(posedge link_clock) disable iff (link_reset) commit);
    COV_READ: cover property (@(posedge link_clock) disable iff (link_reset) state_reg == ST_RDATA_ACK);
    COV_REF_MODE: cover property (@(posedge clock) disable iff (reset) use_ref_reg && !pair_oe_n[0]);
endmodule

// ===== smbus_master.sv
// SMBus controller model that frames byte writes and byte reads on the serial pins.
// Assumes the bench resolves the data line with a pull-up and feeds it back on sda.
`timescale 1ns/1ns
module smbus_master (
    input wire logic link_clock,
    input wire logic sda,
    output logic scl,
    output logic sda_drive
);
    initial begin
        scl = 1'b1;
        sda_drive = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge link_clock);
    endtask
    // Data falls while the clock is high; this also serves as repeated start.
    task automatic start();
        tick(2);
        sda_drive <= 1'b1;
        tick(8);
        scl <= 1'b1;
        tick(8);
        sda_drive <= 1'b0;
        tick(8);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sda_drive <= 1'b0;
        tick(8);
        scl <= 1'b1;
        tick(8);
        sda_drive <= 1'b1;
        tick(8);
    endtask
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sda_drive <= b;
        tick(8);
        scl <= 1'b1;
        tick(8);
        r = sda;
        scl <= 1'b0;
    endtask
    // Eight bits MSB first, then the acknowledge bit.
    task automatic byte_io(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx, output logic ack_in);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_out, ack_in);
    endtask
    // A set bit of nack means that acknowledge was refused.
    task automatic access(input logic [7:0] adr, input logic [7:0] cmd, input logic rd, input logic [7:0] wd,
                          output logic [7:0] rdat, output logic [2:0] nack);
        logic [7:0] junk;
        start();
        byte_io(adr, 1'b1, junk, nack[2]);
        byte_io(cmd, 1'b1, junk, nack[1]);
        if (rd) begin
            start();
            byte_io(adr | 8'h01, 1'b1, junk, nack[0]);
            byte_io(8'hFF, 1'b0, rdat, junk[0]);
        end else begin
            byte_io(wd, 1'b1, rdat, nack[0]);
        end
        stop();
    endtask
endmodule

// ===== tb.sv
// Self-checking bench for the serial control register bank.
// Assumes the package, design files and the SMBus controller model are compiled first.
`timescale 1ns/1ns
module tb;
    logic clock = 1'b0, reset = 1'b1, link_clock = 1'b0, src = 1'b0, refc = 1'b0, src_prev, ref_prev;
    logic scl, sda_drive, sda, sdo, sdo_n, spread, depth, tmode;
    logic [1:0] pt, pc, poe_n, rcnt = 2'h0;
    logic [7:0] rd;
    logic [2:0] nack;
    int miscompares = 0, samples_checked = 0;
    logic [7:0] rst_val [8] = '{8'h7C, 8'h00, 8'hEB, 8'hAF, 8'h01, 8'h00, 8'h13, 8'h35};
    logic [7:0] wmask [8] = '{8'h18, 8'h00, 8'h84, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00};
    logic [15:0] bad [4] = '{16'hD480, 16'hD200, 16'hD2A0, 16'hD288};
    logic [2:0] bad_n [4] = '{3'h7, 3'h3, 3'h3, 3'h3};
    initial forever #50 clock = ~clock;
    initial begin
        #37;
        forever begin
            #63 link_clock = 1'b1;
            #62 link_clock = 1'b0;
        end
    end
    assign sda = (sdo_n === 1'b0) ? sdo : sda_drive;
    always @(posedge clock) begin
        src <= ~src;
        rcnt <= rcnt + 2'h1;
        refc <= rcnt[1];
        src_prev <= src;
        ref_prev <= refc;
    end
    smbus_master master (.link_clock(link_clock), .sda(sda), .scl(scl), .sda_drive(sda_drive));
    // Identification parameters are arbitrary values.
    clockgen_serial_control_regs #(.REVISION_CODE(4'h3), .VENDOR_ID(4'h5), .PAIR_COUNT(2)) DUT (
        .clock(clock), .reset(reset), .link_clock(link_clock), .serial_clock_in(scl), .serial_data_in(sda),
        .serial_data_out(sdo), .serial_data_oe_n(sdo_n), .source_clock_level(src), .ref_clock_level(refc),
        .pair_true_out(pt), .pair_comp_out(pc), .pair_oe_n(poe_n), .spread_enable(spread),
        .spread_depth_select(depth), .test_mode_active(tmode));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [2:0] ofs, input logic [7:0] d, input logic [7:0] outs);
        master.access(8'hD2, {5'h10, ofs}, 1'b0, d, rd, nack);
        check("write acks", {5'h0, nack}, 8'h00);
        repeat (4) @(posedge clock);
        check("outputs", {3'h0, poe_n, spread, depth, tmode}, outs);
    endtask
    task automatic rdchk(input logic [2:0] ofs, input logic [7:0] exp);
        master.access(8'hD2, {5'h10, ofs}, 1'b1, 8'h00, rd, nack);
        check("read acks", {5'h0, nack}, 8'h00);
        check("read data", rd, exp);
    endtask
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        repeat (40) @(posedge clock);
        check("idle outputs", {3'h0, poe_n, spread, depth, tmode}, 8'h02);
        @(negedge clock);
        check("pair level", {4'h0, pt, pc}, {4'h0, src_prev, src_prev, ~src_prev, ~src_prev});
        for (int i = 0; i < 8; i++) rdchk(3'(i), rst_val[i]);
        for (int i = 0; i < 8; i++) begin
            wr(3'(i), 8'h00, (i < 2) ? 8'h1A : 8'h18);
            rdchk(3'(i), rst_val[i] & ~wmask[i]);
        end
        wr(3'h2, 8'h04, 8'h1C);
        wr(3'h0, 8'h18, 8'h04);
        wr(3'h6, 8'h40, 8'h1D);
        wr(3'h6, 8'hC0, 8'h05);
        repeat (4) begin
            @(negedge clock);
            check("test level", {6'h0, pt}, {6'h0, ref_prev, ref_prev});
        end
        wr(3'h6, 8'h00, 8'h04);
        foreach (bad[i]) begin
            master.access(bad[i][15:8], bad[i][7:0], 1'b0, 8'h00, rd, nack);
            check("refused acks", {5'h0, nack}, {5'h0, bad_n[i]});
        end
        rdchk(3'h0, 8'h7C);
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge clock);
        miscompares++;
        end_sim();
    end
endmodule
